// >>> src/palr_responder.v
// Purpose: Device side of an ASCII poll link: parses polls, frames replies.
// Assumes: rx/tx characters come from a UART on the same clock.
// Notes:   Value text arrives already formatted except for zero suppression.
`timescale 1ns/100ps
`include "palr_defines.vh"
module palr_responder #(
   parameter REPLY_CYCLES = `PALR_REPLY_CYCLES,
   parameter ANSWER_CYCLES = `PALR_ANSWER_CYCLES
)(
   input wire clock_i, // System clock, 200 MHz
   input wire rst_n_i, // Async reset, active low
   input wire [7:0] module_addr_i, // Address switch, two BCD digits
   input wire [7:0] rx_data_i, // Received character
   input wire rx_valid_i, // Received character strobe
   output reg [7:0] tx_data_o, // Character to send
   output reg tx_valid_o, // Character valid
   input wire tx_ready_i, // UART takes character
   output reg link_active_o, // Address currently valid
   output reg par_req_o, // Store lookup request
   output reg [13:0] par_id_o, // Identifier, two characters
   output reg [3:0] par_area_o, // Area, 0 is control area
   input wire par_ack_i, // Store lookup done
   input wire par_valid_i, // Identifier known
   input wire par_has_chan_i, // Identifier carries channels
   input wire par_last_i, // Identifier ends the list
   input wire [13:0] par_next_id_i, // Next identifier in list
   input wire [6:0] val_char_i, // Value text character
   input wire val_keep_i, // Never blank this character
   input wire val_item_end_i, // Last character of one value
   input wire val_list_end_i, // Last value of the identifier
   input wire val_valid_i, // Value character valid
   output wire val_ready_o // Buffer has room
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_FETCH = 4'h1;
   localparam [3:0] ST_STX = 4'h2;
   localparam [3:0] ST_ID0 = 4'h3;
   localparam [3:0] ST_ID1 = 4'h4;
   localparam [3:0] ST_DATA = 4'h5;
   localparam [3:0] ST_END = 4'h6;
   localparam [3:0] ST_BCC = 4'h7;
   localparam [3:0] ST_WAIT = 4'h8;
   localparam [3:0] ST_REPLAY = 4'h9;
   localparam [3:0] ST_EOT = 4'hA;
   localparam [2:0] DP_CH0 = 3'h0;
   localparam [2:0] DP_CH1 = 3'h1;
   localparam [2:0] DP_SP = 3'h2;
   localparam [2:0] DP_VAL = 3'h3;
   localparam [2:0] DP_COMMA = 3'h4;

   reg [7:0] addr_s1_reg;
   reg [7:0] addr_s2_reg;
   reg [3:0] state_reg;
   reg [2:0] dp_reg;
   reg [41:0] hist_reg;
   reg [2:0] n_reg;
   reg [13:0] next_id_reg;
   reg has_chan_reg;
   reg last_id_reg;
   reg last_blk_reg;
   reg first_blk_reg;
   reg lead_reg;
   reg [3:0] ch_tens_reg;
   reg [3:0] ch_ones_reg;
   reg [7:0] blk_cnt_reg;
   reg [7:0] blk_len_reg;
   reg [7:0] rp_idx_reg;
   reg [6:0] bcc_reg;
   reg [`PALR_TIMER_W-1:0] timer_reg;
   reg fifo_clr_reg;
   reg [6:0] replay_mem [0:`PALR_BLK_MAX-1];
   reg emit_en;
   reg [6:0] emit_byte;
   reg [6:0] addr_a, addr_b;
   reg has_addr, has_area, form_ok;
   wire [6:0] rx_char;
   wire [`PALR_FIFO_W-1:0] fifo_head;
   wire fifo_valid;
   wire fifo_pop;
   wire can_load;
   wire addr_ok;
   wire addr_match;
   wire [6:0] val_out;
   wire [3:0] area_num;

   // ---------------------------------------------------------------------
   // Value text buffer
   // ---------------------------------------------------------------------
   palr_fifo #(
      .WIDTH(`PALR_FIFO_W),
      .DEPTH(`PALR_FIFO_D),
      .AW(`PALR_FIFO_AW)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clr_i(fifo_clr_reg),
      .in_data_i({val_list_end_i, val_item_end_i, val_keep_i, val_char_i}),
      .in_valid_i(val_valid_i),
      .in_ready_o(val_ready_o),
      .out_data_o(fifo_head),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // ---------------------------------------------------------------------
   // Poll decoding
   // ---------------------------------------------------------------------
   // Parity or eighth bit from the UART is dropped; only 7-bit codes count
   assign rx_char = rx_data_i[6:0];
   assign can_load = ~tx_valid_o | tx_ready_i;
   assign addr_match = (addr_a == {`PALR_DIGIT_HI, addr_s2_reg[7:4]})
      && (addr_b == {`PALR_DIGIT_HI, addr_s2_reg[3:0]});
   // An address sent earlier in the link still counts
   assign addr_ok = has_addr ? addr_match : link_active_o;
   assign area_num = hist_reg[17:14];
   // Leading zeros of a value go out as spaces
   assign val_out = (lead_reg && !fifo_head[7] && !fifo_head[8]
      && fifo_head[6:0] == `PALR_ZERO) ? `PALR_SPACE : fifo_head[6:0];
   assign fifo_pop = emit_en && state_reg == ST_DATA && dp_reg == DP_VAL;

   // Split the collected characters into address, area and identifier
   always @* begin
      has_addr = 1'b0;
      has_area = 1'b0;
      addr_a = hist_reg[41:35];
      addr_b = hist_reg[34:28];
      if (n_reg == 3'h6) begin
         has_addr = 1'b1;
         has_area = 1'b1;
      end else if (n_reg == 3'h4) begin
         has_area = link_active_o && hist_reg[27:21] == `PALR_AREA_LETTER;
         has_addr = ~has_area;
         addr_a = hist_reg[27:21];
         addr_b = hist_reg[20:14];
      end
      form_ok = (n_reg == 3'h2 || n_reg == 3'h4 || n_reg == 3'h6)
         && (!has_area || (hist_reg[27:21] == `PALR_AREA_LETTER
         && hist_reg[20:14] >= `PALR_AREA_ZERO
         && hist_reg[20:14] <= `PALR_AREA_EIGHT));
   end

   // ---------------------------------------------------------------------
   // Next character to hand to the UART
   // ---------------------------------------------------------------------
   always @* begin
      emit_en = 1'b0;
      emit_byte = `PALR_EOT;
      if (can_load) begin
         case (state_reg)
            ST_STX: begin
               emit_en = 1'b1;
               emit_byte = `PALR_STX;
            end
            ST_ID0: begin
               emit_en = 1'b1;
               emit_byte = par_id_o[13:7];
            end
            ST_ID1: begin
               emit_en = 1'b1;
               emit_byte = par_id_o[6:0];
            end
            ST_DATA: begin
               if (blk_cnt_reg != `PALR_BLK_SPLIT) begin
                  case (dp_reg)
                     DP_CH0: begin
                        emit_en = 1'b1;
                        emit_byte = {`PALR_DIGIT_HI, ch_tens_reg};
                     end
                     DP_CH1: begin
                        emit_en = 1'b1;
                        emit_byte = {`PALR_DIGIT_HI, ch_ones_reg};
                     end
                     DP_SP: begin
                        emit_en = 1'b1;
                        emit_byte = `PALR_SPACE;
                     end
                     DP_VAL: begin
                        // Colons of soak times pass through as text
                        emit_en = fifo_valid;
                        emit_byte = val_out;
                     end
                     default: begin
                        emit_en = 1'b1;
                        emit_byte = `PALR_COMMA;
                     end
                  endcase
               end
            end
            ST_END: begin
               emit_en = 1'b1;
               emit_byte = last_blk_reg ? `PALR_ETX : `PALR_ETB;
            end
            ST_BCC: begin
               emit_en = 1'b1;
               emit_byte = bcc_reg;
            end
            ST_REPLAY: begin
               emit_en = 1'b1;
               emit_byte = replay_mem[rp_idx_reg];
            end
            ST_EOT: begin
               emit_en = 1'b1;
               emit_byte = `PALR_EOT;
            end
            default: emit_en = 1'b0;
         endcase
      end
   end

   // Copy of the block for resending
   always @(posedge clock_i) begin
      if (emit_en && state_reg != ST_REPLAY && state_reg != ST_EOT) begin
         replay_mem[(state_reg == ST_STX) ? 8'h00 : blk_cnt_reg] <= emit_byte;
      end
   end

   // ---------------------------------------------------------------------
   // Control sequence
   // ---------------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_s1_reg <= 8'h00;
         addr_s2_reg <= 8'h00;
         state_reg <= ST_IDLE;
         dp_reg <= DP_CH0;
         hist_reg <= 42'h000_0000_0000;
         n_reg <= 3'h0;
         next_id_reg <= 14'h0000;
         has_chan_reg <= 1'b0;
         last_id_reg <= 1'b0;
         last_blk_reg <= 1'b0;
         first_blk_reg <= 1'b0;
         lead_reg <= 1'b1;
         ch_tens_reg <= 4'h0;
         ch_ones_reg <= 4'h1;
         blk_cnt_reg <= 8'h00;
         blk_len_reg <= 8'h00;
         rp_idx_reg <= 8'h00;
         bcc_reg <= 7'h00;
         timer_reg <= {`PALR_TIMER_W{1'b0}};
         fifo_clr_reg <= 1'b0;
         tx_data_o <= 8'h00;
         tx_valid_o <= 1'b0;
         link_active_o <= 1'b0;
         par_req_o <= 1'b0;
         par_id_o <= 14'h0000;
         par_area_o <= 4'h0;
      end else begin
         addr_s1_reg <= module_addr_i;
         addr_s2_reg <= addr_s1_reg;
         fifo_clr_reg <= 1'b0;
         timer_reg <= (state_reg == ST_FETCH || state_reg == ST_WAIT)
            ? timer_reg + {{(`PALR_TIMER_W-1){1'b0}}, 1'b1} : {`PALR_TIMER_W{1'b0}};
         // UART hand-over and check character
         if (emit_en) begin
            tx_data_o <= {1'b0, emit_byte};
            tx_valid_o <= 1'b1;
            blk_cnt_reg <= blk_cnt_reg + 8'h01;
            bcc_reg <= bcc_reg ^ emit_byte;
         end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               // Only a complete poll leads to a reply
               if (rx_valid_i) begin
                  if (rx_char == `PALR_EOT) begin
                     link_active_o <= 1'b0;
                     n_reg <= 3'h0;
                  end else if (rx_char == `PALR_ENQ) begin
                     n_reg <= 3'h0;
                     if (addr_ok && form_ok) begin
                        link_active_o <= 1'b1;
                        par_id_o <= hist_reg[13:0];
                        // No area given means control area
                        par_area_o <= has_area ? area_num : 4'h0;
                        par_req_o <= 1'b1;
                        fifo_clr_reg <= 1'b1;
                        state_reg <= ST_FETCH;
                     end else if (addr_ok) begin
                        state_reg <= ST_EOT;
                     end else begin
                        link_active_o <= 1'b0;
                     end
                  end else begin
                     hist_reg <= {hist_reg[34:0], rx_char};
                     n_reg <= (n_reg == 3'h7) ? n_reg : n_reg + 3'h1;
                  end
               end
            end
            ST_FETCH: begin
               if (par_ack_i) begin
                  par_req_o <= 1'b0;
                  has_chan_reg <= par_has_chan_i;
                  last_id_reg <= par_last_i;
                  next_id_reg <= par_next_id_i;
                  first_blk_reg <= 1'b1;
                  lead_reg <= 1'b1;
                  ch_tens_reg <= 4'h0;
                  ch_ones_reg <= 4'h1;
                  dp_reg <= par_has_chan_i ? DP_CH0 : DP_VAL;
                  state_reg <= par_valid_i ? ST_STX : ST_EOT;
               end else if (timer_reg >= REPLY_CYCLES - 1) begin
                  par_req_o <= 1'b0;
                  state_reg <= ST_EOT;
               end
            end
            ST_STX: begin
               if (emit_en) begin
                  blk_cnt_reg <= 8'h01;
                  bcc_reg <= 7'h00;
                  last_blk_reg <= 1'b0;
                  state_reg <= first_blk_reg ? ST_ID0 : ST_DATA;
               end
            end
            ST_ID0: begin
               if (emit_en) begin
                  state_reg <= ST_ID1;
               end
            end
            ST_ID1: begin
               if (emit_en) begin
                  state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (can_load && blk_cnt_reg == `PALR_BLK_SPLIT) begin
                  state_reg <= ST_END;
               end else if (emit_en) begin
                  case (dp_reg)
                     DP_CH0: dp_reg <= DP_CH1;
                     DP_CH1: dp_reg <= DP_SP;
                     DP_SP: dp_reg <= DP_VAL;
                     DP_VAL: begin
                        if (fifo_head[6:0] != `PALR_ZERO) begin
                           lead_reg <= 1'b0;
                        end
                        if (fifo_head[8] && fifo_head[9]) begin
                           last_blk_reg <= 1'b1;
                           state_reg <= ST_END;
                        end else if (fifo_head[8]) begin
                           dp_reg <= DP_COMMA;
                        end
                     end
                     default: begin
                        lead_reg <= 1'b1;
                        dp_reg <= has_chan_reg ? DP_CH0 : DP_VAL;
                        ch_ones_reg <= (ch_ones_reg == 4'h9) ? 4'h0 : ch_ones_reg + 4'h1;
                        if (ch_ones_reg == 4'h9) begin
                           ch_tens_reg <= ch_tens_reg + 4'h1;
                        end
                     end
                  endcase
               end
            end
            ST_END: begin
               if (emit_en) begin
                  state_reg <= ST_BCC;
               end
            end
            ST_BCC: begin
               if (emit_en) begin
                  blk_len_reg <= blk_cnt_reg + 8'h01;
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (rx_valid_i) begin
                  timer_reg <= {`PALR_TIMER_W{1'b0}};
                  if (rx_char == `PALR_ACK) begin
                     first_blk_reg <= 1'b0;
                     if (!last_blk_reg) begin
                        state_reg <= ST_STX;
                     end else if (last_id_reg) begin
                        state_reg <= ST_EOT;
                     end else begin
                        par_id_o <= next_id_reg;
                        par_req_o <= 1'b1;
                        fifo_clr_reg <= 1'b1;
                        state_reg <= ST_FETCH;
                     end
                  end else if (rx_char == `PALR_NAK) begin
                     rp_idx_reg <= 8'h00;
                     state_reg <= ST_REPLAY;
                  end else if (rx_char == `PALR_EOT) begin
                     link_active_o <= 1'b0;
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg <= ST_EOT;
                  end
               end else if (timer_reg >= ANSWER_CYCLES - 1) begin
                  state_reg <= ST_EOT;
               end
            end
            ST_REPLAY: begin
               if (emit_en) begin
                  rp_idx_reg <= rp_idx_reg + 8'h01;
                  if (rp_idx_reg == blk_len_reg - 8'h01) begin
                     state_reg <= ST_WAIT;
                  end
               end
            end
            ST_EOT: begin
               if (emit_en) begin
                  link_active_o <= 1'b0;
                  n_reg <= 3'h0;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
         // Host EOT during a reply abandons it
         if (rx_valid_i && rx_char == `PALR_EOT && state_reg != ST_IDLE
            && state_reg != ST_WAIT) begin
            link_active_o <= 1'b0;
            par_req_o <= 1'b0;
            state_reg <= ST_IDLE;
         end
      end
   end

endmodule // palr_responder

// >>> src/palr_defines.vh
// Purpose: Shared constants of the polled ASCII link responder.
// Assumes: 200 MHz system clock, characters handed over by an external UART.
// Notes:   Character codes are 7 bits wide; counts are derived from times.
//
// Summary of operation
// - Control codes: EOT 04, ENQ 05, ACK 06, NAK 15, STX 02, ETB 17, ETX 03.
// - Every character on the link is a 7-bit ASCII code.
// - Host starts every exchange; device only ever answers.
// - Poll accepted only when the address equals the configured module address.
// - Received address stays valid until EOT is sent or received; the code also drops it on a poll with another address.
// - Area codes one to eight map to areas 1-8; zero means control area.
// - Missing area means control area; area on non-area identifier is ignored.
// - Reply is STX, identifier, data, ETB or ETX, then check character.
// - Replies over 136 bytes are split by ETB; each block restarts with STX.
// - Space between channel and value; comma between value and next channel.
// - Channel as two digits with zeros; leading value zeros replaced by spaces.
// - Soak times use a colon, up to 99:59 or 199:59.
// - Check character is XOR of all bytes after STX through ETB or ETX.
// - Device sends EOT on invalid identifier, bad format, or all data sent.
// - Device stays silent on a wrongly received address; host times out.
// - ACK makes the device send the next identifier, up to the list end.
// - NAK makes the device resend the identical reply, every time.
// - No host answer within about 3 s makes the device send EOT.
// - Any other host answer makes the device send EOT.
// - Device starts its reply within 50 ms of ENQ, ACK or NAK.
// - Frame is 7 or 8 data bits, none/even/odd parity, one stop bit.
`ifndef PALR_DEFINES_VH
`define PALR_DEFINES_VH

// ----------------------------------------------------------------------------
// Transmission control and text characters
// ----------------------------------------------------------------------------
`define PALR_EOT 7'h04
`define PALR_ENQ 7'h05
`define PALR_ACK 7'h06
`define PALR_NAK 7'h15
`define PALR_STX 7'h02
`define PALR_ETB 7'h17
`define PALR_ETX 7'h03
`define PALR_SPACE 7'h20
`define PALR_COMMA 7'h2C
`define PALR_ZERO 7'h30
`define PALR_AREA_LETTER 7'h4B
`define PALR_AREA_ZERO 7'h30
`define PALR_AREA_EIGHT 7'h38
`define PALR_DIGIT_HI 3'h3
`define PALR_CHAR_W 7

// ----------------------------------------------------------------------------
// Block sizing and buffering
// ----------------------------------------------------------------------------
`define PALR_BLK_MAX 8'h88
`define PALR_BLK_SPLIT 8'h86
`define PALR_FIFO_W 10
`define PALR_FIFO_D 32
`define PALR_FIFO_AW 5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PALR_CLK_HZ 200000000
`define PALR_REPLY_MS 50
`define PALR_ANSWER_S 3
`define PALR_REPLY_CYCLES (`PALR_REPLY_MS * (`PALR_CLK_HZ / 1000))
`define PALR_ANSWER_CYCLES (`PALR_ANSWER_S * `PALR_CLK_HZ)
`define PALR_TIMER_W 30

`endif

// >>> src/palr_fifo.v
// Purpose: Value text buffer between parameter store and reply framer.
// Assumes: Single clock; clear empties it in one cycle.
// Notes:   Ready and valid on both sides; in_ready_o comes from a flop.
`timescale 1ns/100ps
module palr_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 32,
   parameter AW = 5
)(
   input wire clock_i, // System clock
   input wire rst_n_i, // Async reset, active low
   input wire clr_i, // Synchronous flush
   input wire [WIDTH-1:0] in_data_i, // Fill data
   input wire in_valid_i, // Fill data valid
   output reg in_ready_o, // Room available
   output wire [WIDTH-1:0] out_data_o, // Head word
   output wire out_valid_o, // Head word valid
   input wire out_ready_i // Drain accepts head
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   wire [AW:0] count_next;

   // ---------------------------------------------------------------------
   // Handshake terms
   // ---------------------------------------------------------------------
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_valid_o = (count_reg != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr_reg];
   assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // Storage array
   always @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   // Pointers, fill count and registered ready
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_o <= 1'b0;
      end else if (clr_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_o <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         count_reg <= count_next;
         in_ready_o <= (count_next < DEPTH);
      end
   end

endmodule // palr_fifo

// >>> tb/palr_responder_sva.sv
// Purpose: Port checker for palr_responder.
// Assumes: One clock domain, reset active low.
// Notes:   Bound into every palr_responder instance below.
`timescale 1ns/100ps
module palr_responder_sva #(
   parameter REPLY_CYCLES = 64,
   parameter ANSWER_CYCLES = 200
)(
   input wire clock_i, // Clock
   input wire rst_n_i, // Reset
   input wire [7:0] rx_data_i, // Rx char
   input wire rx_valid_i, // Rx strobe
   input wire [7:0] tx_data_o, // Tx char
   input wire tx_valid_o, // Tx valid
   input wire tx_ready_i, // Tx taken
   input wire link_active_o, // Link held
   input wire par_req_o, // Lookup
   input wire [3:0] par_area_o, // Area
   input wire par_ack_i, // Lookup done
   input wire par_valid_i // Id known
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Character shape and handshakes
   chk_tx_seven: assert property (tx_valid_o |-> !tx_data_o[7])
      else $error("tx bit 7 set");
   chk_tx_hold: assert property (tx_valid_o && !tx_ready_i
      |=> tx_valid_o && $stable(tx_data_o)) else $error("tx char not held");
   chk_req_drop: assert property (par_req_o && par_ack_i |=> !par_req_o)
      else $error("lookup not released");
   chk_req_quiet: assert property (par_req_o |-> !tx_valid_o)
      else $error("tx during lookup");
   // Poll decoding and reply start
   chk_area_range: assert property (par_req_o |-> par_area_o <= 4'h8)
      else $error("area out of range");
   chk_eot_drop: assert property (rx_valid_i && rx_data_i[6:0] == 7'h04
      |-> ##[1:2] !link_active_o) else $error("link kept after EOT");
   chk_stx_first: assert property (par_req_o && par_ack_i && par_valid_i
      |-> ##[1:3] (tx_valid_o && tx_data_o == 8'h02)) else $error("no STX after lookup");
   chk_bad_eot: assert property (par_req_o && par_ack_i && !par_valid_i
      |-> ##[1:4] (tx_valid_o && tx_data_o == 8'h04)) else $error("no EOT on unknown id");
endmodule // palr_responder_sva
bind palr_responder palr_responder_sva #(.REPLY_CYCLES(REPLY_CYCLES), .ANSWER_CYCLES(ANSWER_CYCLES))
   u_sva (.*);

// >>> tb/palr_store_model.sv
// Purpose: Parameter store answering lookups of the responder.
// Assumes: Acks the cycle after a request, then streams value text 015.
// Notes:   bad_id_i makes it report the identifier as unknown.
`timescale 1ns/100ps
module palr_store_model (
   input wire clock_i, // Clock
   input wire par_req_o, // Lookup
   input wire bad_id_i, // Unknown id
   input wire more_i, // Not last id
   input wire val_ready_o, // Room
   output reg par_ack_i, // Done
   output reg par_valid_i, // Known
   output reg par_has_chan_i, // Channels
   output reg par_last_i, // List end
   output reg [13:0] par_next_id_i, // Next id
   output reg [6:0] val_char_i, // Text
   output reg val_keep_i, // Keep zero
   output reg val_item_end_i, // Item end
   output reg val_list_end_i, // List end
   output reg val_valid_i // Text valid
);
   integer i;
   // Lookup answer, then value text held until taken
   initial begin
      {par_ack_i, par_valid_i, val_valid_i, val_keep_i, val_item_end_i, val_list_end_i} = 6'h00;
      {par_has_chan_i, par_last_i, par_next_id_i, val_char_i} = {2'h3, 14'h18B1, 7'h30};
      forever begin
         @(posedge clock_i);
         if (par_req_o) begin
            par_ack_i <= 1'b1;
            par_valid_i <= !bad_id_i;
            par_last_i <= !more_i;
            @(posedge clock_i);
            par_ack_i <= 1'b0;
            for (i = 0; i < 3 && !bad_id_i; i = i + 1) begin
               val_valid_i <= 1'b1;
               val_char_i <= (i == 2) ? 7'h35 : 7'h30 + i[6:0];
               {val_item_end_i, val_list_end_i} <= {2{i == 2}};
               do @(posedge clock_i); while (!val_ready_o);
            end
            val_valid_i <= 1'b0;
         end
      end
   end
endmodule // palr_store_model

// >>> tb/polled_ascii_link_responder_tb.sv
// Purpose: Self-checking bench of the poll responder.
// Assumes: Bench acts as host; inputs change on falling edges.
// Notes:   Short reply and answer timers keep the run brief.
`timescale 1ns/100ps
module polled_ascii_link_responder_tb;
   reg clock_i = 0, rst_n_i = 0, rx_valid_i = 0, tx_ready_i = 0, bad_id_i = 0, more_i = 0;
   reg [7:0] module_addr_i = 8'h01, rx_data_i = 8'h00, c;
   reg [79:0] exp_p = 80'h02313030312020313503;
   reg [3:0] area_seen = 4'hF;
   wire [7:0] tx_data_o;
   wire tx_valid_o, link_active_o, par_req_o, par_ack_i, par_valid_i, par_has_chan_i, par_last_i;
   wire val_keep_i, val_item_end_i, val_list_end_i, val_valid_i, val_ready_o;
   wire [13:0] par_id_o, par_next_id_i;
   wire [3:0] par_area_o;
   wire [6:0] val_char_i;
   integer err_total = 0, n_tests = 0, k;
   palr_responder #(.REPLY_CYCLES(64), .ANSWER_CYCLES(200)) dut (.*);
   palr_store_model store (.*);
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) if (par_req_o) area_seen <= par_area_o;
   // Compare, host byte out, reply byte in
   task chk(input [7:0] got, input [7:0] want);
      begin
         n_tests = n_tests + 1;
         if (got !== want) begin
            err_total = err_total + 1;
            $display("MISMATCH %0t got %h want %h", $time, got, want);
         end
      end
   endtask
   task rx(input [6:0] ch);
      begin rx_data_i = {1'b0, ch}; rx_valid_i = 1'b1; @(negedge clock_i);
         rx_valid_i = 1'b0; @(negedge clock_i); end
   endtask
   task get(output [7:0] ch);
      integer n;
      begin
         ch = 8'hFF;
         for (n = 0; n < 400 && tx_valid_o !== 1'b1; n = n + 1) @(negedge clock_i);
         if (tx_valid_o === 1'b1) ch = tx_data_o;
         tx_ready_i = 1'b1; @(negedge clock_i); tx_ready_i = 1'b0; @(negedge clock_i);
      end
   endtask
   // EOT, address, optional area, identifier 10, ENQ
   task poll(input [6:0] a, input [6:0] ar);
      begin
         rx(7'h04); rx(7'h30); rx(a);
         if (ar != 7'h00) begin rx(7'h4B); rx(ar); end
         rx(7'h31); rx(7'h30); rx(7'h05);
      end
   endtask
   task reply;
      integer i;
      reg [7:0] b;
      begin
         b = 8'h00;
         for (i = 0; i < 10; i = i + 1) begin
            get(c);
            chk(c, exp_p[8*(9-i) +: 8]);
            if (i > 0) b = b ^ c;
         end
         get(c);
         chk(c, b);
      end
   endtask
   // Scenarios
   task t_good;
      begin
         more_i = 1'b1; poll(7'h31, 7'h00); reply; chk({4'h0, area_seen}, 8'h00);
         more_i = 1'b0; rx(7'h15); reply;
         exp_p[63:56] = 8'h31; rx(7'h06); reply; chk(par_id_o[7:0], 8'hB1);
         exp_p[63:56] = 8'h30; rx(7'h06); get(c); chk(c, 8'h04);
         $display("good poll, replay, advance and list end done");
      end
   endtask
   task t_area;
      begin
         for (k = 0; k < 9; k = k + 4) begin
            poll(7'h31, 7'h30 + k[6:0]); reply; chk({4'h0, area_seen}, k[7:0]);
         end
         $display("area codes done");
      end
   endtask
   task t_addr;
      begin poll(7'h32, 7'h00); get(c); chk(c, 8'hFF); $display("foreign address done"); end
   endtask
   task t_bad;
      begin bad_id_i = 1'b1; poll(7'h31, 7'h00); get(c); chk(c, 8'h04);
         bad_id_i = 1'b0; $display("unknown id done"); end
   endtask
   task t_quiet;
      begin poll(7'h31, 7'h00); reply; get(c); chk(c, 8'h04); $display("silence done"); end
   endtask
   task t_junk;
      begin poll(7'h31, 7'h00); reply; rx(7'h41); get(c); chk(c, 8'h04);
         $display("odd answer done"); end
   endtask
   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_total);
         if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Reset, run all scenarios; watchdog cuts a hang
   initial begin
      repeat (10) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clock_i);
      t_good; t_area; t_addr; t_bad; t_quiet; t_junk;
      test_done;
   end
   initial begin #100000; err_total = err_total + 1; test_done; end
endmodule // polled_ascii_link_responder_tb
